// ==== design/exception_priority_controller.sv ====
`default_nettype none
`include "epc_defs.svh"

// Notes on behaviour
// - eight levels per system handler and interrupt
// - level zero ranks after reset, nmi, hard fault
// - all priority fields reset to zero
// - equal priority: lower position wins
// - grouping splits pre-emption and subpriority
// - stack on entry, unstack on return, handler mode
// - vector fetch runs alongside state push
// - pending at return chains without restore/save
// - stack pointer loaded from vector entry zero
// - nmi at position 2, never pre-empted
// - nmi raised only by software write
// - blocked or disabled fault escalates to hard fault
// - bus fault position 5, software enable
// - usage fault position 6, synchronous
// - service call position 11, synchronous
// - debug monitor 12, enabled, only if urgent
// - pendable service 14, software pended only
// - system tick 15 pended on timer fire
// - peripheral lines from 16, synchronised, prioritised
// - fixed peripheral line assignment
// - reserved peripheral lines never raise
module exception_priority_controller (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] irq_in,
  input  wire logic [31:0] irq_enable,
  input  wire logic [2:0]  prigroup,
  input  wire logic        prio_wr_en,
  input  wire logic [5:0]  prio_wr_pos,
  input  wire logic [2:0]  prio_wr_val,
  input  wire logic        nmi_set_sw,
  input  wire logic        pendable_service_request_set_sw,
  input  wire logic        system_tick_exception_fire,
  input  wire logic        bus_fault_req,
  input  wire logic        bus_fault_enable,
  input  wire logic        usage_fault_req,
  input  wire logic        svc_req,
  input  wire logic        debug_mon_req,
  input  wire logic        debug_mon_enable,
  output logic             vec_req,
  output logic [5:0]       vec_index,
  input  wire logic        vec_ack,
  input  wire logic [31:0] vec_data,
  output logic             stack_push_req,
  input  wire logic        stack_push_done,
  output logic             stack_pop_req,
  input  wire logic        stack_pop_done,
  input  wire logic        handler_return,
  output logic             handler_mode,
  output logic [5:0]       active_exc,
  output logic [31:0]      sp_init,
  output logic             sp_valid
);
  import epc_pkg::*;

  localparam logic [`EPC_NUM_POS-1:0] SETTABLE_MASK = `EPC_SETTABLE;
  ctl_t                    q_ff;
  ctl_t                    nxt_q;
  logic [1:0]              sub_bits;
  logic                    win_valid;
  logic [5:0]              win;
  logic [3:0]              win_key;
  logic [3:0]              win_grp;
  logic [3:0]              cur_lvl;
  logic [3:0]              rem_lvl;
  logic [3:0]              best_key;
  logic [5:0]              best_act;
  logic [`EPC_NUM_POS-1:0] act_rem;
  logic                    tie_bad;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // ranking helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] key_of(input int i);
    if (i == `EPC_POS_NMI) begin
      key_of = `EPC_KEY_NMI;
    end else if (i == `EPC_POS_HARD) begin
      key_of = `EPC_KEY_HARD;
    end else begin
      key_of = {1'b0, q_ff.prio[i]} + `EPC_KEY_OFS;
    end
  endfunction

  function automatic logic [3:0] grp_of(input int i);
    if (i == `EPC_POS_NMI) begin
      grp_of = `EPC_KEY_NMI;
    end else if (i == `EPC_POS_HARD) begin
      grp_of = `EPC_KEY_HARD;
    end else begin
      grp_of = {1'b0, q_ff.prio[i] >> sub_bits} + `EPC_KEY_OFS;
    end
  endfunction

  assign sub_bits = (prigroup > `EPC_SUB_MAX) ? 2'h3 : prigroup[1:0];

  // ----------------------------------------------------------------
  // winner and current level search
  // ----------------------------------------------------------------
  always_comb begin
    win_valid = 1'b0;
    win       = 6'h00;
    win_key   = `EPC_LVL_NONE;
    cur_lvl   = `EPC_LVL_NONE;
    rem_lvl   = `EPC_LVL_NONE;
    best_key  = `EPC_LVL_NONE;
    best_act  = 6'h00;
    tie_bad   = 1'b0;
    act_rem   = q_ff.act & ~(48'h0000_0000_0001 << q_ff.cur);
    for (int i = `EPC_NUM_POS - 1; i >= 0; i--) begin
      if (q_ff.pend[i] && key_of(i) <= win_key) begin
        win_valid = 1'b1;
        win       = 6'(i);
        win_key   = key_of(i);
      end
      if (q_ff.act[i] && grp_of(i) < cur_lvl) begin
        cur_lvl = grp_of(i);
      end
      if (act_rem[i] && grp_of(i) < rem_lvl) begin
        rem_lvl = grp_of(i);
      end
      if (act_rem[i] && key_of(i) <= best_key) begin
        best_key = key_of(i);
        best_act = 6'(i);
      end
    end
    win_grp = win_valid ? grp_of(int'(win)) : `EPC_LVL_NONE;
    for (int i = 0; i < `EPC_NUM_POS; i++) begin
      if (win_valid && q_ff.pend[i] && 6'(i) < win && key_of(i) == win_key) begin
        tie_bad = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.sync1 = irq_in;
    nxt_q.sync2 = q_ff.sync1;
    if (prio_wr_en && prio_wr_pos < 6'(`EPC_NUM_POS) && SETTABLE_MASK[prio_wr_pos]) begin
      nxt_q.prio[prio_wr_pos] = prio_wr_val;
    end
    case (q_ff.st)
      ST_BOOT: begin
        if (vec_ack) begin
          nxt_q.sp = vec_data;
          nxt_q.st = ST_THREAD;
        end
      end
      ST_THREAD: begin
        if (win_valid) begin
          nxt_q.st           = ST_ENTRY;
          nxt_q.cur          = win;
          nxt_q.act[win]     = 1'b1;
          nxt_q.pend[win]    = 1'b0;
        end
      end
      ST_ENTRY: begin
        nxt_q.push_seen = q_ff.push_seen | stack_push_done;
        nxt_q.vec_seen  = q_ff.vec_seen | vec_ack;
        if ((q_ff.push_seen || stack_push_done) && (q_ff.vec_seen || vec_ack)) begin
          nxt_q.st        = ST_HANDLER;
          nxt_q.push_seen = 1'b0;
          nxt_q.vec_seen  = 1'b0;
        end
      end
      ST_CHAIN: begin
        if (vec_ack) begin
          nxt_q.st = ST_HANDLER;
        end
      end
      ST_HANDLER: begin
        if (handler_return) begin
          nxt_q.act[q_ff.cur] = 1'b0;
          if (win_valid && win_grp < rem_lvl) begin
            nxt_q.st        = ST_CHAIN;
            nxt_q.cur       = win;
            nxt_q.act[win]  = 1'b1;
            nxt_q.pend[win] = 1'b0;
          end else begin
            nxt_q.st = ST_EXIT;
          end
        end else if (win_valid && win_grp < cur_lvl) begin
          nxt_q.st        = ST_ENTRY;
          nxt_q.cur       = win;
          nxt_q.act[win]  = 1'b1;
          nxt_q.pend[win] = 1'b0;
        end
      end
      ST_EXIT: begin
        if (stack_pop_done) begin
          if (|q_ff.act) begin
            nxt_q.st  = ST_HANDLER;
            nxt_q.cur = best_act;
          end else begin
            nxt_q.st = ST_THREAD;
          end
        end
      end
      default: begin
        nxt_q.st = ST_BOOT;
      end
    endcase

    // pend sets come last so a set in the clearing cycle wins
    nxt_q.pend[`EPC_NUM_POS-1:`EPC_IRQ_BASE] = nxt_q.pend[`EPC_NUM_POS-1:`EPC_IRQ_BASE]
                                             | (q_ff.sync2 & irq_enable & `EPC_IRQ_VALID);
    if (nmi_set_sw) begin
      nxt_q.pend[`EPC_POS_NMI] = 1'b1;
    end
    if (pendable_service_request_set_sw) begin
      nxt_q.pend[`EPC_POS_PENDABLE_SERVICE_REQUEST] = 1'b1;
    end
    if (system_tick_exception_fire) begin
      nxt_q.pend[`EPC_POS_TICK] = 1'b1;
    end
    if (bus_fault_req) begin
      if (!bus_fault_enable || grp_of(`EPC_POS_BUS) >= cur_lvl) begin
        nxt_q.pend[`EPC_POS_HARD] = 1'b1;
      end else begin
        nxt_q.pend[`EPC_POS_BUS] = 1'b1;
      end
    end
    if (usage_fault_req) begin
      if (grp_of(`EPC_POS_USAGE) >= cur_lvl) begin
        nxt_q.pend[`EPC_POS_HARD] = 1'b1;
      end else begin
        nxt_q.pend[`EPC_POS_USAGE] = 1'b1;
      end
    end
    if (svc_req) begin
      if (grp_of(`EPC_POS_SVC) >= cur_lvl) begin
        nxt_q.pend[`EPC_POS_HARD] = 1'b1;
      end else begin
        nxt_q.pend[`EPC_POS_SVC] = 1'b1;
      end
    end
    if (debug_mon_req && debug_mon_enable && grp_of(`EPC_POS_DBG) < cur_lvl) begin
      nxt_q.pend[`EPC_POS_DBG] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // core side outputs
  // ----------------------------------------------------------------
  assign vec_req        = (q_ff.st == ST_BOOT) || (q_ff.st == ST_CHAIN)
                        || ((q_ff.st == ST_ENTRY) && !q_ff.vec_seen);
  assign stack_push_req = (q_ff.st == ST_ENTRY) && !q_ff.push_seen;
  assign stack_pop_req  = (q_ff.st == ST_EXIT);
  assign handler_mode   = (q_ff.st == ST_HANDLER);
  assign vec_index      = q_ff.cur;
  assign active_exc     = q_ff.cur;
  assign sp_init        = q_ff.sp;
  assign sp_valid       = (q_ff.st != ST_BOOT);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  prio_reset_zero_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> (q_ff.prio == '0))
    else $error("priority not zero under reset");

  reserved_quiet_a: assert property (
    (q_ff.pend[`EPC_NUM_POS-1:`EPC_IRQ_BASE] & ~`EPC_IRQ_VALID) == '0)
    else $error("reserved line pending");

  tie_order_a: assert property (!tie_bad)
    else $error("equal priority tie not won by lower position");

  nmi_hold_a: assert property (
    (q_ff.st == ST_HANDLER && q_ff.cur == 6'(`EPC_POS_NMI) && !handler_return) |=> (q_ff.st == ST_HANDLER))
    else $error("nmi handler pre-empted");

  fetch_with_push_a: assert property (
    (q_ff.st != ST_ENTRY ##1 q_ff.st == ST_ENTRY) |-> (vec_req && stack_push_req))
    else $error("vector fetch not concurrent with push");

  tail_chain_a: assert property (
    (q_ff.st == ST_HANDLER && handler_return && win_valid && win_grp < rem_lvl)
    |=> (q_ff.st == ST_CHAIN && !stack_pop_req && !stack_push_req) ##1 !stack_pop_req)
    else $error("tail chain did not skip restore");

  boot_stack_a: assert property (
    (q_ff.st == ST_BOOT && vec_ack) |=> (sp_init == $past(vec_data) && sp_valid && vec_index == 6'h00))
    else $error("stack pointer not loaded from entry zero");

  bus_escalate_a: assert property (
    (bus_fault_req && !bus_fault_enable) |=> q_ff.pend[`EPC_POS_HARD] || q_ff.act[`EPC_POS_HARD])
    else $error("disabled bus fault not escalated");

  dbg_block_a: assert property (
    (!debug_mon_enable && debug_mon_req && !q_ff.pend[`EPC_POS_DBG]) |=> !q_ff.pend[`EPC_POS_DBG])
    else $error("disabled debug monitor pended");

  exit_thread_a: assert property (
    (q_ff.st == ST_EXIT && stack_pop_done && q_ff.act == '0) |=> (q_ff.st == ST_THREAD && !handler_mode))
    else $error("unstack did not return to thread");

  preempt_group_a: assert property (
    (q_ff.st == ST_HANDLER && !handler_return && !(win_valid && win_grp < cur_lvl)) |=> (q_ff.st != ST_ENTRY))
    else $error("pre-emption without better group");

  thread_entry_a: assert property (
    (q_ff.st == ST_THREAD && win_valid) |=> (q_ff.st == ST_ENTRY && vec_index == $past(win) && vec_req))
    else $error("winner not presented on entry");

  sync_path_a: assert property (
    $rose(q_ff.pend[`EPC_IRQ_BASE]) |-> $past(irq_in[0], `EPC_SYNC_DEPTH))
    else $error("peripheral line pended without synchronised request");

  nmi_source_a: assert property (
    $rose(q_ff.pend[`EPC_POS_NMI]) |-> $past(nmi_set_sw))
    else $error("nmi pended without software write");

  pendable_service_request_source_a: assert property (
    $rose(q_ff.pend[`EPC_POS_PENDABLE_SERVICE_REQUEST]) |-> $past(pendable_service_request_set_sw))
    else $error("pendable service pended without software write");

endmodule

`default_nettype wire

// ==== common/epc_defs.svh ====
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// ----------------------------------------------------------------
// exception positions and sizes
// ----------------------------------------------------------------
`define EPC_NUM_POS       48
`define EPC_NUM_IRQ       32
`define EPC_IRQ_BASE      16
`define EPC_PRIO_W        3
`define EPC_SYNC_DEPTH    3
`define EPC_POS_STACK     6'h00
`define EPC_POS_NMI       2
`define EPC_POS_HARD      3
`define EPC_POS_BUS       5
`define EPC_POS_USAGE     6
`define EPC_POS_SVC       11
`define EPC_POS_DBG       12
`define EPC_POS_PENDABLE_SERVICE_REQUEST    14
`define EPC_POS_TICK      15

// ----------------------------------------------------------------
// masks and levels
// ----------------------------------------------------------------
`define EPC_IRQ_VALID     32'h367C_00A7
`define EPC_SETTABLE      48'hFFFF_FFFF_D870
`define EPC_PRIO_RESET    3'h0
`define EPC_KEY_NMI       4'h0
`define EPC_KEY_HARD      4'h1
`define EPC_KEY_OFS       4'h2
`define EPC_LVL_NONE      4'hF
`define EPC_SUB_MAX       3'h3

`endif

// ==== common/epc_pkg.sv ====
`default_nettype none

package epc_pkg;
`include "epc_defs.svh"

  typedef enum logic [2:0] {
    ST_BOOT    = 3'b000,
    ST_THREAD  = 3'b001,
    ST_ENTRY   = 3'b010,
    ST_CHAIN   = 3'b011,
    ST_HANDLER = 3'b100,
    ST_EXIT    = 3'b101
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t                                st;
    logic [`EPC_NUM_IRQ-1:0]                   sync1;
    logic [`EPC_NUM_IRQ-1:0]                   sync2;
    logic [`EPC_NUM_POS-1:0]                   pend;
    logic [`EPC_NUM_POS-1:0]                   act;
    logic [`EPC_NUM_POS-1:0][`EPC_PRIO_W-1:0] prio;
    logic [5:0]                                cur;
    logic [31:0]                               sp;
    logic                                      push_seen;
    logic                                      vec_seen;
  } ctl_t;

endpackage

`default_nettype wire

// ==== tb/core_model.sv ====
`default_nettype none

// ------------------------------------------------------------
// core side: answers vector, push and pop requests
// ------------------------------------------------------------
module answer_unit (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       req,
  input  wire logic [1:0] lat,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 3'h0;
      done   <= 1'b0;
    end else begin
      done   <= req && !done && (cnt_ff >= {1'b0, lat});
      cnt_ff <= (req && !done) ? cnt_ff + 3'h1 : 3'h0;
    end
  end
endmodule

module core_model #(
  parameter logic [31:0] SP_VALUE = 32'h2000_0800
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  lat,
  input  wire logic        vec_req,
  input  wire logic        stack_push_req,
  input  wire logic        stack_pop_req,
  output logic             vec_ack,
  output logic [31:0]      vec_data,
  output logic             stack_push_done,
  output logic             stack_pop_done
);
  timeunit 1ns;
  timeprecision 1ps;
  answer_unit i_vec (.clk(clk), .reset(reset), .req(vec_req), .lat(lat), .done(vec_ack));
  answer_unit i_push (.clk(clk), .reset(reset), .req(stack_push_req), .lat(lat), .done(stack_push_done));
  answer_unit i_pop (.clk(clk), .reset(reset), .req(stack_pop_req), .lat(lat), .done(stack_pop_done));
  assign vec_data = vec_ack ? SP_VALUE : ~SP_VALUE;
endmodule

`default_nettype wire

// ==== tb/tb_exception_priority_controller.sv ====
`default_nettype none
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t %s", $time, m); end end

module tb_exception_priority_controller;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SP_VALUE = 32'h2000_0800;
  logic        clk, reset, prio_wr_en, bus_fault_enable, debug_mon_enable, handler_return;
  logic [31:0] irq_in, irq_enable, vec_data, sp_init;
  logic [2:0]  prigroup, prio_wr_val;
  logic [5:0]  prio_wr_pos, vec_index, active_exc;
  logic [6:0]  ev;
  logic [1:0]  lat;
  logic        vec_req, vec_ack, stack_push_req, stack_push_done, stack_pop_req, stack_pop_done;
  logic        handler_mode, sp_valid;
  int          err_count = 0, checked = 0, cycles = 0, pop_cnt = 0, par_cnt = 0;
  int          line_list[14] = '{0, 1, 2, 5, 7, 18, 19, 20, 21, 22, 25, 26, 28, 29};

  exception_priority_controller i_dut (.clk(clk), .reset(reset), .irq_in(irq_in), .irq_enable(irq_enable),
    .prigroup(prigroup), .prio_wr_en(prio_wr_en), .prio_wr_pos(prio_wr_pos), .prio_wr_val(prio_wr_val),
    .nmi_set_sw(ev[0]), .pendable_service_request_set_sw(ev[1]), .system_tick_exception_fire(ev[2]), .bus_fault_req(ev[3]),
    .bus_fault_enable(bus_fault_enable), .usage_fault_req(ev[4]), .svc_req(ev[5]), .debug_mon_req(ev[6]),
    .debug_mon_enable(debug_mon_enable), .vec_req(vec_req), .vec_index(vec_index), .vec_ack(vec_ack),
    .vec_data(vec_data), .stack_push_req(stack_push_req), .stack_push_done(stack_push_done),
    .stack_pop_req(stack_pop_req), .stack_pop_done(stack_pop_done), .handler_return(handler_return),
    .handler_mode(handler_mode), .active_exc(active_exc), .sp_init(sp_init), .sp_valid(sp_valid));
  core_model #(.SP_VALUE(SP_VALUE)) i_core (.clk(clk), .reset(reset), .lat(lat), .vec_req(vec_req),
    .stack_push_req(stack_push_req), .stack_pop_req(stack_pop_req), .vec_ack(vec_ack), .vec_data(vec_data),
    .stack_push_done(stack_push_done), .stack_pop_done(stack_pop_done));

  // ------------------------------------------------------------
  // clock, monitors and helpers
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (stack_pop_req === 1'b1) pop_cnt++;
    if (vec_req === 1'b1 && stack_push_req === 1'b1) par_cnt++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic do_reset();
    int n;
    n = 0;
    reset = 1'b1; ev = 7'h00; irq_in = 32'h0; prigroup = 3'h0; handler_return = 1'b0; lat = 2'h0;
    prio_wr_en = 1'b0; prio_wr_pos = 6'h00; prio_wr_val = 3'h0; bus_fault_enable = 1'b1;
    debug_mon_enable = 1'b1;
    irq_enable = 32'hFFFF_FFFF;
    tick(10);
    `CHK(vec_req, 1'b1, "boot fetch")
    `CHK(vec_index, 6'h00, "boot entry")
    `CHK(sp_valid, 1'b0, "early sp")
    reset = 1'b0;
    while (sp_valid !== 1'b1 && n < 10) begin tick(); n++; end
    `CHK(sp_init, SP_VALUE, "sp load")
  endtask

  task automatic wprio(input logic [5:0] pos, input logic [2:0] val);
    prio_wr_en = 1'b1; prio_wr_pos = pos; prio_wr_val = val;
    tick();
    prio_wr_en = 1'b0;
    tick();
  endtask

  task automatic pulse(input logic [6:0] e, input logic [31:0] l);
    ev = e; irq_in = l;
    tick();
    ev = 7'h00; irq_in = 32'h0;
  endtask

  task automatic ret();
    handler_return = 1'b1;
    tick();
    handler_return = 1'b0;
  endtask

  task automatic wait_hm(input logic v);
    int n;
    n = 0;
    while (handler_mode !== v && n < 20) begin tick(); n++; end
    `CHK(handler_mode, v, "handler mode")
  endtask

  task automatic settle(input logic [5:0] old);
    int n;
    n = 0;
    while (active_exc === old && n < 20) begin tick(); n++; end
    tick(4);
  endtask

  task automatic try_one(input logic [5:0] exp);
    int p;
    if (exp == 6'h00) tick(12);
    wait_hm(exp != 6'h00);
    if (exp != 6'h00) begin
      `CHK(active_exc, exp, "entry position")
      `CHK(vec_index, exp, "vector index")
      p = pop_cnt;
      ret();
      wait_hm(1'b0);
      tick(4);
      `CHK(pop_cnt > p, 1'b1, "state restore")
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic lines_scan();
    logic [31:0] used;
    used = 32'h0;
    foreach (line_list[i]) used[line_list[i]] = 1'b1;
    for (int n = 0; n < 32; n++) begin
      pulse(7'h00, 32'h1 << n);
      try_one(used[n] ? 6'(16 + n) : 6'h00);
    end
    irq_enable = 32'hFFFF_FFFE;
    pulse(7'h00, 32'h1);
    try_one(6'h00);
    irq_enable = 32'hFFFF_FFFF;
  endtask

  task automatic events();
    logic [6:0] ev_tab[9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h08, 7'h10, 7'h20, 7'h40, 7'h40};
    logic [5:0] exp_tab[9] = '{6'h02, 6'h0E, 6'h0F, 6'h05, 6'h03, 6'h06, 6'h0B, 6'h0C, 6'h00};
    for (int i = 0; i < 9; i++) begin
      bus_fault_enable = (i != 4);
      debug_mon_enable = (i != 8);
      pulse(ev_tab[i], 32'h0);
      try_one(exp_tab[i]);
    end
  endtask

  task automatic tie_chain();
    int p, q;
    do_reset();
    q = par_cnt;
    pulse(7'h00, 32'h3);
    wait_hm(1'b1);
    `CHK(active_exc, 6'h10, "tie order")
    `CHK(par_cnt > q, 1'b1, "fetch with push")
    p = pop_cnt;
    q = par_cnt;
    ret();
    settle(6'h10);
    `CHK(active_exc, 6'h11, "chained entry")
    `CHK(pop_cnt, p, "no restore in chain")
    `CHK(par_cnt, q, "no save in chain")
    try_one(6'h11);
  endtask

  task automatic nmi_scn();
    do_reset();
    wprio(6'h10, 3'h2);
    wprio(6'h0F, 3'h5);
    pulse(7'h01, 32'h0);
    wait_hm(1'b1);
    pulse(7'h14, 32'h1);
    tick(6);
    `CHK(active_exc, 6'h02, "nmi held")
    ret();
    settle(6'h02);
    `CHK(active_exc, 6'h03, "hard fault next")
    ret();
    settle(6'h03);
    `CHK(active_exc, 6'h10, "urgent level next")
  endtask

  task automatic grouping();
    for (int g = 0; g < 2; g++) begin
      do_reset();
      lat = 2'h3;
      prigroup = 3'(g);
      wprio(6'h10, 3'h3);
      wprio(6'h11, 3'h2);
      pulse(7'h00, 32'h1);
      wait_hm(1'b1);
      pulse(7'h00, 32'h2);
      tick(12);
      `CHK(active_exc, (g == 0) ? 6'h11 : 6'h10, "pre-emption group")
    end
  endtask

  initial begin
    do_reset();
    lines_scan();
    events();
    tie_chain();
    nmi_scn();
    grouping();
    wrap_up();
  end
endmodule

`default_nettype wire
